// [rtl/mnre_exec.sv]
// execution unit for multiply-by-file, negate and return-from-interrupt
// assumes one AHB-Lite master, single word transfers, synchronous inputs
//
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module mnre_exec
  import mnre_pkg::*;
#(
  parameter int FILE_DEPTH = 16,
  parameter int STACK_DEPTH = 16
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  localparam int FW = $clog2(FILE_DEPTH);
  localparam int SW = $clog2(STACK_DEPTH);
  function automatic logic is_mul(input logic [15:0] op);
    is_mul = (op[15:8] == OP_MUL_HI);
  endfunction
  function automatic logic is_neg(input logic [15:0] op);
    is_neg = (op[15:9] == OP_NEG_HI);
  endfunction
  function automatic logic is_ret(input logic [15:0] op);
    is_ret = (op == OP_RETURN);
  endfunction
  mnre_state_t state, next_state;
  logic [1:0] q, next_q;
  logic [15:0] instr, next_instr;
  logic [7:0] working_register, next_working_register;
  logic [15:0] prod, next_prod;
  mnre_flags_t flags, next_flags;
  logic global_interrupt_disable, next_global_interrupt_disable;
  logic [15:0] pc, next_pc;
  logic [15:0] stack [STACK_DEPTH];
  logic [15:0] next_stack [STACK_DEPTH];
  logic [SW-1:0] sp, next_sp;
  logic [7:0] mem [FILE_DEPTH];
  logic [7:0] next_mem [FILE_DEPTH];
  logic [7:0] faddr, next_faddr;
  logic ad_valid, next_ad_valid;
  logic ad_write, next_ad_write;
  logic [7:0] ad_addr, next_ad_addr;
  logic [31:0] next_hrdata;
  logic [FW-1:0] op_idx;
  logic [7:0] file_at;
  logic [15:0] top_entry;
  logic [7:0] neg_res;
  logic [8:0] neg_sum;
  logic [4:0] neg_low;
  logic bus_wr;

  // operand fetch and negate arithmetic, all combinational
  assign op_idx = instr[FW-1:0];
  assign file_at = mem[op_idx];
  assign top_entry = stack[sp - SW'(1)];
  assign neg_sum = {1'b0, ~working_register} + 9'h001;
  assign neg_low = {1'b0, ~working_register[3:0]} + 5'h01;
  assign neg_res = neg_sum[7:0];
  assign bus_wr = ad_valid & ad_write;

  // ahb address phase capture and registered read data
  always_comb
  begin
    next_ad_valid = hsel & hready & htrans[1];
    next_ad_write = hwrite;
    next_ad_addr = haddr[7:0];
    next_hrdata = hrdata;
    if (hsel & hready & htrans[1] & ~hwrite)
    begin
      case (haddr[7:0])
        OFF_INSTR: next_hrdata = {16'h0000, instr};
        OFF_WORKING_REGISTER: next_hrdata = {24'h000000, working_register};
        OFF_PROD: next_hrdata = {16'h0000, prod};
        OFF_STATUS: next_hrdata = {23'h000000, state != ST_IDLE, 3'h0, global_interrupt_disable,
                                   flags};
        OFF_PC: next_hrdata = {16'h0000, pc};
        OFF_PUSH: next_hrdata = 32'(sp);
        OFF_FADDR: next_hrdata = {24'h000000, faddr};
        OFF_FDATA: next_hrdata = {24'h000000, mem[faddr[FW-1:0]]};
        default: next_hrdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ad_valid <= 1'b0;
      ad_write <= 1'b0;
      ad_addr <= RST_BYTE;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      ad_valid <= next_ad_valid;
      ad_write <= next_ad_write;
      ad_addr <= next_ad_addr;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1; // zero wait states, always okay
      hresp <= 1'b0;
    end
  end

  // sequencer and bus writes; execution wins over a same-cycle bus write
  always_comb
  begin
    next_state = state;
    next_q = q;
    next_instr = instr;
    next_working_register = working_register;
    next_prod = prod;
    next_flags = flags;
    next_global_interrupt_disable = global_interrupt_disable;
    next_pc = pc;
    next_stack = stack;
    next_sp = sp;
    next_mem = mem;
    next_faddr = faddr;
    if (bus_wr)
    begin
      case (ad_addr)
        OFF_INSTR:
        begin
          // a new opcode is only taken while idle
          if (state == ST_IDLE)
          begin
            next_instr = hwdata[15:0];
            next_state = ST_EXEC;
          end
        end
        OFF_WORKING_REGISTER: next_working_register = hwdata[7:0];
        OFF_STATUS:
        begin
          next_flags = hwdata[BIT_OVERFLOW_FLAG:BIT_C]; // same bit order as the struct
          next_global_interrupt_disable = hwdata[BIT_GLOBAL_INTERRUPT_DISABLE];
        end
        OFF_PUSH:
        begin
          next_stack[sp] = hwdata[15:0];
          next_sp = sp + SW'(1);
        end
        OFF_FADDR: next_faddr = hwdata[7:0];
        OFF_FDATA: next_mem[faddr[FW-1:0]] = hwdata[7:0];
        default: next_q = q;
      endcase
    end
    case (state)
      ST_IDLE: next_q = 2'h0;
      ST_EXEC:
      begin
        next_q = q + 2'h1;
        if (q == Q_CLEAR && is_ret(instr))
        begin
          next_global_interrupt_disable = 1'b0;
        end
        if (q == Q_WRITE)
        begin
          next_state = is_ret(instr) ? ST_NOP : ST_IDLE;
          // unsigned multiply; leave operands, flags alone
          if (is_mul(instr))
          begin
            next_prod = {8'h00, working_register} * {8'h00, file_at};
          end
          if (is_neg(instr))
          begin
            next_mem[op_idx] = neg_res;
            if (!instr[8])
            begin
              next_working_register = neg_res;
            end
            next_flags.c = neg_sum[8];
            next_flags.digit_carry_flag = neg_low[4];
            next_flags.z = (neg_res == 8'h00);
            next_flags.overflow_flag = working_register[7] & neg_res[7];
          end
          if (is_ret(instr))
          begin
            next_pc = top_entry;
            next_sp = sp - SW'(1);
          end
        end
      end
      ST_NOP:
      begin
        next_q = q + 2'h1;
        if (q == Q_WRITE)
        begin
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
        next_q = 2'h0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      q <= 2'h0;
      instr <= RST_WORD;
      working_register <= RST_BYTE;
      prod <= RST_WORD;
      flags <= '0;
      global_interrupt_disable <= RST_GLOBAL_INTERRUPT_DISABLE;
      pc <= RST_WORD;
      sp <= '0;
      faddr <= RST_BYTE;
      for (int i = 0; i < STACK_DEPTH; i++)
      begin
        stack[i] <= RST_WORD;
      end
      for (int i = 0; i < FILE_DEPTH; i++)
      begin
        mem[i] <= RST_BYTE;
      end
    end
    else
    begin
      state <= next_state;
      q <= next_q;
      instr <= next_instr;
      working_register <= next_working_register;
      prod <= next_prod;
      flags <= next_flags;
      global_interrupt_disable <= next_global_interrupt_disable;
      pc <= next_pc;
      sp <= next_sp;
      faddr <= next_faddr;
      stack <= next_stack;
      mem <= next_mem;
    end
  end

  // checks on the execution behaviour
  a_mul_product: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_EXEC && q == Q_WRITE && is_mul(instr))
    |=> prod == {8'h00, $past(working_register)} * {8'h00, $past(file_at)})
    else $error("product pair wrong after multiply");
  a_mul_keeps: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_EXEC && q == Q_WRITE && is_mul(instr) && !bus_wr)
    |=> $stable(working_register) && $stable(file_at))
    else $error("multiply changed an operand");
  a_mul_flags: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_EXEC && q == Q_WRITE && is_mul(instr) && !bus_wr) |=> $stable(flags))
    else $error("multiply changed status flags");
  a_neg_value: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_EXEC && q == Q_WRITE && is_neg(instr))
    |=> file_at == 8'(8'h00 - $past(working_register)))
    else $error("negate result wrong");
  a_neg_dest: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_EXEC && q == Q_WRITE && is_neg(instr) && !bus_wr)
    |=> instr[8] ? $stable(working_register) : working_register == file_at)
    else $error("negate destination wrong");
  a_neg_flags: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_EXEC && q == Q_WRITE && is_neg(instr))
    |=> flags.z == (file_at == 8'h00) && flags.c == ($past(working_register) == 8'h00)
        && flags.overflow_flag == ($past(working_register) == 8'h80))
    else $error("negate flags wrong");
  a_ret_pop: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_EXEC && q == Q_WRITE && is_ret(instr))
    |=> pc == $past(top_entry) && sp == $past(sp) - SW'(1))
    else $error("return did not pop stack");
  a_ret_length: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_EXEC && q == 2'h0 && is_ret(instr))
    |-> (state == ST_EXEC) [*4] ##1 (state == ST_NOP) [*4] ##1 state == ST_IDLE)
    else $error("return not two instruction cycles");
  a_ret_order: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_EXEC && q == Q_CLEAR && is_ret(instr) && !bus_wr)
    |=> !global_interrupt_disable && $stable(sp) && $stable(pc))
    else $error("interrupt enable or pop out of order");
endmodule

// [rtl/mnre_pkg.sv]
// constants, types and register map of the multiply/negate/return execution unit
// assumes a single 100 MHz clock and an AHB-Lite master holding the register bus
// Contract
// - opcode 0x34xx multiplies working register by file
// - 16-bit product split into high/low bytes; the unit keeps it whole in one 16-bit prod register at OFF_PROD
// - multiply leaves working register and file unchanged
// - multiply touches no status flag
// - 0010110s negates working register in one cycle
// - select 0 writes both, 1 writes file
// - negate updates overflow, carry, digit carry, zero
// - opcode 0x0005 pops stack into PC, two cycles
// - return clears global interrupt disable, status bit 4
package mnre_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_WORKING_REGISTER = 8'h04;
  localparam logic [7:0] OFF_PROD = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_PC = 8'h10;
  localparam logic [7:0] OFF_PUSH = 8'h14;
  localparam logic [7:0] OFF_FADDR = 8'h18;
  localparam logic [7:0] OFF_FDATA = 8'h1C;
  // status register field positions
  localparam int BIT_C = 0;
  localparam int BIT_DIGIT_CARRY_FLAG = 1;
  localparam int BIT_Z = 2;
  localparam int BIT_OVERFLOW_FLAG = 3;
  localparam int BIT_GLOBAL_INTERRUPT_DISABLE = 4;
  localparam int BIT_BUSY = 8;
  // opcode patterns
  localparam logic [7:0] OP_MUL_HI = 8'h34;
  localparam logic [6:0] OP_NEG_HI = 7'h16;
  localparam logic [15:0] OP_RETURN = 16'h0005;
  // quarter-cycle indices inside one instruction cycle
  localparam logic [1:0] Q_CLEAR = 2'h2;
  localparam logic [1:0] Q_WRITE = 2'h3;
  // values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic RST_GLOBAL_INTERRUPT_DISABLE = 1'b1;
  // arithmetic status flags
  typedef struct packed {
    logic overflow_flag;
    logic z;
    logic digit_carry_flag;
    logic c;
  } mnre_flags_t;
  // one-hot execution states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_NOP = 3'b100
  } mnre_state_t;
endpackage

// [testbench/mnre_exec_tb.sv]
// bench for the multiply, negate and return execution unit
// assumes the unit is the only ahb-lite slave, zero wait states
`timescale 1ns/1ns
module mnre_exec_tb;
  import mnre_pkg::*;
  logic clk;
  logic rst_n;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] rd;
  logic [15:0] mw;
  logic [15:0] mf;
  logic [7:0] res;
  logic [3:0] fa;
  logic [4:0] sts;
  int miscompares;
  int tests_run;
  int cycles;
  // operand tables; zero and all-ones are the awkward cases
  logic [7:0] mul_w [3] = '{8'hC4, 8'h00, 8'hFF};
  logic [7:0] mul_f [3] = '{8'hB5, 8'h7F, 8'hFF};
  logic [7:0] neg_w [4] = '{8'h3A, 8'h00, 8'h80, 8'h01};
  logic neg_s [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

  // hsize tied to word, hready looped back as the lone slave
  mnre_exec #(.FILE_DEPTH(16), .STACK_DEPTH(16)) mnre_exec_i (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

  // free-running clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic results();
    $display("tests_run %0d miscompares %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // hang guard, well above the few hundred cycles the tests need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      miscompares++;
      results();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one single transfer; waits on hready in both phases, no fixed latency
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  // issue an opcode and poll busy under a bounded count
  task automatic execute(input logic [15:0] op);
    int n;
    n = 0;
    bus(1'b1, OFF_INSTR, {16'h0000, op});
    bus(1'b0, OFF_STATUS, 32'h0);
    while (rd[BIT_BUSY] !== 1'b0 && n < 20)
    begin
      bus(1'b0, OFF_STATUS, 32'h0);
      n++;
    end
    check("busy", 32'h0, {31'h0, rd[BIT_BUSY]});
  endtask

  // main sequence
  initial
  begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    miscompares = 0;
    tests_run = 0;
    cycles = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, OFF_STATUS, 32'h0);
    check("status_reset", 32'h00000010, rd);
    // unmapped place reads zero and drops writes
    bus(1'b1, 8'h40, 32'hDEADBEEF);
    bus(1'b0, 8'h40, 32'h0);
    check("unmapped", 32'h0, rd);
    // multiply; upper opcode address bits alias onto the file
    for (int i = 0; i < 3; i++)
    begin
      fa = 4'(i + 3);
      sts = (i == 1) ? 5'h00 : 5'h0F;
      mw = {8'h00, mul_w[i]};
      mf = {8'h00, mul_f[i]};
      bus(1'b1, OFF_FADDR, {28'h0, fa});
      bus(1'b1, OFF_FDATA, {16'h0, mf});
      bus(1'b1, OFF_WORKING_REGISTER, {16'h0, mw});
      bus(1'b1, OFF_STATUS, {27'h0, sts});
      execute({8'h34, 4'h1, fa});
      bus(1'b0, OFF_PROD, 32'h0);
      check("product", {16'h0, mw * mf}, rd);
      bus(1'b0, OFF_WORKING_REGISTER, 32'h0);
      check("mul_work_reg", {16'h0, mw}, rd);
      bus(1'b0, OFF_FDATA, 32'h0);
      check("mul_file", {16'h0, mf}, rd);
      bus(1'b0, OFF_STATUS, 32'h0);
      check("mul_flags", {27'h0, sts}, rd);
    end
    // negate with both select values and flag corner cases
    for (int i = 0; i < 4; i++)
    begin
      fa = 4'(i + 8);
      res = ~neg_w[i] + 8'h01;
      bus(1'b1, OFF_FADDR, {28'h0, fa});
      bus(1'b1, OFF_FDATA, 32'h000000AB);
      bus(1'b1, OFF_WORKING_REGISTER, {24'h0, neg_w[i]});
      bus(1'b1, OFF_STATUS, 32'h0);
      execute({7'h16, neg_s[i], 4'h0, fa});
      bus(1'b0, OFF_FDATA, 32'h0);
      check("neg_file", {24'h0, res}, rd);
      bus(1'b0, OFF_WORKING_REGISTER, 32'h0);
      check("neg_work_reg", {24'h0, neg_s[i] ? neg_w[i] : res}, rd);
      bus(1'b0, OFF_STATUS, 32'h0);
      check("neg_flags", {28'h0, neg_w[i] == 8'h80, res == 8'h00,
        neg_w[i][3:0] == 4'h0, neg_w[i] == 8'h00}, rd);
    end
    // return twice; a multiply written while busy must be dropped
    bus(1'b1, OFF_STATUS, 32'h00000010);
    bus(1'b1, OFF_PUSH, 32'h00001234);
    bus(1'b1, OFF_PUSH, 32'h0000ABCD);
    bus(1'b0, OFF_PUSH, 32'h0);
    check("push_depth", 32'h00000002, rd);
    bus(1'b1, OFF_INSTR, {16'h0, OP_RETURN});
    bus(1'b1, OFF_INSTR, 32'h00003400);
    bus(1'b0, OFF_STATUS, 32'h0);
    check("ret_mid", 32'h10, {27'h0, rd[8:4]});
    execute(16'h0000);
    bus(1'b0, OFF_PC, 32'h0);
    check("ret_pc", 32'h0000ABCD, rd);
    bus(1'b0, OFF_STATUS, 32'h0);
    check("ret_int_enable", 32'h0, {31'h0, rd[BIT_GLOBAL_INTERRUPT_DISABLE]});
    bus(1'b0, OFF_PROD, 32'h0);
    check("busy_drop", 32'h0000FE01, rd);
    bus(1'b1, OFF_STATUS, 32'h00000010);
    execute(OP_RETURN);
    bus(1'b0, OFF_PC, 32'h0);
    check("ret_pc2", 32'h00001234, rd);
    bus(1'b0, OFF_STATUS, 32'h0);
    check("ret_int_enable2", 32'h0, {31'h0, rd[BIT_GLOBAL_INTERRUPT_DISABLE]});
    bus(1'b0, OFF_PUSH, 32'h0);
    check("ret_depth", 32'h0, rd);
    bus(1'b0, OFF_INSTR, 32'h0);
    check("ret_opcode", {16'h0, OP_RETURN}, rd);
    check("hresp", 32'h0, {31'h0, hresp});
    results();
  end
endmodule
